// ===== design/ldur_level_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
module ldur_level_ctrl
  import ldur_pkg::*;
(
  input  wire logic                               i_clk,
  input  wire logic                               i_sys_rst,
  input  wire logic                               i_chip_reset_n,
  input  wire logic                               i_sclk,
  input  wire logic                               i_cs_n,
  input  wire logic                               i_mosi,
  output var  logic                               o_miso,
  output var  logic                               o_busy_n_out,
  output var  logic                               o_busy_n_oe,
  output var  logic [NUM_BANKS*SLOTS*DATA_W-1:0]  o_level_code,
  output var  logic                               o_levels_grounded,
  output var  logic                               o_test_pins_grounded,
  output var  logic [NUM_BANKS-1:0]               o_pin_elec_active,
  output var  logic [NUM_BANKS-1:0]               o_pmu_active,
  output var  logic                               o_sys_pmu_closed,
  output var  logic [DATA_W-1:0]                  o_alarm_cfg,
  output var  logic                               o_deglitch_active
);
  localparam int DG_W = $clog2(DEGLITCH_CYC + 1);
  localparam logic [DG_W-1:0] DG_LOAD  = DG_W'(DEGLITCH_CYC);
  localparam logic [DG_W-1:0] DG_ONE   = DG_W'(1);
  localparam logic [2:0]      NO_CTRL  = 3'h7;
  localparam logic [2:0]      CTRL_PIN = 3'h1;
  localparam logic [2:0]      CTRL_PMU = 3'h2;
  localparam int              OVH_SLOT = int'(ADDR_OVH);

  typedef enum logic [1:0] {RS_IDLE, RS_ARM, RS_HOLD, RS_CLOCKED} ldur_rst_e;

  typedef struct packed {
    logic                                       pin_s1;
    logic                                       pin_s2;
    ldur_rst_e                                  rst;
    logic [6:0]                                 rst_cnt;
    logic [NUM_BANKS-1:0][NUM_CTRL-1:0][DATA_W-1:0] ctrl;
    logic [NUM_BANKS-1:0]                       mode;
    logic                                       corr_en;
    logic [DATA_W-1:0]                          gain;
    logic [DATA_W-1:0]                          offset;
    logic [DATA_W-1:0]                          alarm_cfg;
    logic [NUM_BANKS-1:0][SLOTS-1:0][DATA_W-1:0] queued;
    logic [NUM_BANKS-1:0][SLOTS-1:0][DATA_W-1:0] level;
    logic [NUM_BANKS-1:0]                       upd_banks;
    logic [2:0]                                 upd_cnt;
    logic [NUM_BANKS-1:0]                       dg_banks;
    logic [DG_W-1:0]                            dg_cnt;
    logic                                       dg_run;
    logic                                       busy;
    logic                                       force_gnd;
    logic [NUM_BANKS-1:0]                       pin_act;
    logic [NUM_BANKS-1:0]                       pmu_act;
    logic                                       sys_pmu;
  } ldur_core_s;

  ldur_core_s st;
  ldur_core_s n;

  ldur_spi_if bus ();

  ldur_spi_front u_front (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_sclk    (i_sclk),
    .i_cs_n    (i_cs_n),
    .i_mosi    (i_mosi),
    .o_miso    (o_miso),
    .bus       (bus.front)
  );

  function automatic logic [2:0] ctrl_idx(input logic [ADDR_W-1:0] a);
    case (a)
      ADDR_VHH:  ctrl_idx = 3'h0;
      ADDR_PIN:  ctrl_idx = CTRL_PIN;
      ADDR_PMU:  ctrl_idx = CTRL_PMU;
      ADDR_CMP:  ctrl_idx = 3'h3;
      ADDR_EDGE: ctrl_idx = 3'h4;
      default:   ctrl_idx = NO_CTRL;
    endcase
  endfunction : ctrl_idx

  function automatic logic [DATA_W-1:0] corr_code(input logic [DATA_W-1:0] x,
                                                  input logic [DATA_W-1:0] m,
                                                  input logic [DATA_W-1:0] c);
    logic [2*DATA_W:0] prod;
    prod      = (33'({1'b0, m}) + 33'h000000001) * 33'(x);
    corr_code = prod[2*DATA_W-1:DATA_W] + c - CODE_MID;
  endfunction : corr_code

  logic                 rw;
  logic                 wr;
  logic [1:0]           chs;
  logic [ADDR_W-1:0]    addr;
  logic [DATA_W-1:0]    wdata;
  logic [2:0]           ci;
  logic [NUM_BANKS-1:0] upd_req;
  logic                 trig;
  logic [NUM_BANKS-1:0] trig_banks;
  logic                 enter_hold;
  logic                 rd_ch;
  logic [ADDR_W-1:0]    rd_addr;
  logic [2:0]           rd_ci;

  always_comb begin
    n          = st;
    upd_req    = '0;
    trig       = 1'b0;
    trig_banks = '0;
    rw         = bus.frame[RW_POS];
    chs        = {bus.frame[CH1_POS], bus.frame[CH0_POS]};
    addr       = bus.frame[ADDR_MSB:ADDR_LSB];
    wdata      = bus.frame[DATA_W-1:0];
    ci         = ctrl_idx(addr);
    n.pin_s1   = i_chip_reset_n;
    n.pin_s2   = st.pin_s1;
    wr         = bus.frame_done && !rw && (st.rst == RS_IDLE) && st.pin_s2;
    // converter data writes
    if (wr && addr <= DAC_ADDR_LAST) begin
      for (int b = 0; b < NUM_BANKS; b++) begin
        if (chs[b]) begin
          n.queued[b][addr[3:0]] = st.corr_en ? corr_code(wdata, st.gain, st.offset) : wdata;
          // overvolt-high on channel 0 belongs to bank 1
          if (!st.mode[(b == 0 && addr == ADDR_OVH) ? 1 : b]) begin
            upd_req[(b == 0 && addr == ADDR_OVH) ? 1 : b] = 1'b1;
          end
        end
      end
    end
    // converter control: mode per bank, apply strobe, chip-wide correction
    if (wr && addr == ADDR_LVL_CTRL) begin
      for (int b = 0; b < NUM_BANKS; b++) begin
        if (chs[b]) begin
          n.mode[b] = wdata[MODE_BIT];
          if (wdata[APPLY_BIT] && st.mode[b]) begin
            upd_req[b] = 1'b1;
          end
        end
      end
      if (chs[0]) begin
        n.corr_en = wdata[CORR_EN_BIT];
      end
    end
    if (wr && chs[0] && addr == ADDR_GAIN) begin
      n.gain = wdata;
    end
    if (wr && chs[0] && addr == ADDR_OFFSET) begin
      n.offset = wdata;
    end
    if (wr && chs[0] && addr == ADDR_ALARM_CFG) begin
      n.alarm_cfg = wdata;
    end
    if (wr && ci != NO_CTRL) begin
      for (int b = 0; b < NUM_BANKS; b++) begin
        if (chs[b] && (b == 0 || addr != ADDR_VHH)) begin
          n.ctrl[b][ci] = wdata;
        end
      end
    end
    if (wr && chs[0] && addr == ADDR_SPI_CTRL && wdata[SOFT_RST_BIT]) begin
      n.rst = RS_ARM;
    end
    // update start after four sclk edges
    if (upd_req != '0) begin
      n.upd_banks = st.upd_banks | upd_req;
      n.upd_cnt   = '0;
    end else if (st.upd_banks != '0 && bus.sclk_rise) begin
      if (st.upd_cnt == UPDATE_DELAY_EDGES - 3'h1) begin
        trig        = 1'b1;
        trig_banks  = st.upd_banks;
        n.upd_banks = '0;
        n.upd_cnt   = '0;
      end else begin
        n.upd_cnt = st.upd_cnt + 3'h1;
      end
    end
    // shared deglitch timer
    if (st.dg_run) begin
      if (st.dg_cnt == DG_ONE) begin
        for (int b = 0; b < NUM_BANKS; b++) begin
          for (int s = 0; s < SLOTS; s++) begin
            if (st.dg_banks[b] && !(b == 0 && s == OVH_SLOT)) begin
              n.level[b][s] = st.queued[b][s];
            end
          end
        end
        if (st.dg_banks[1]) begin
          n.level[0][OVH_SLOT] = st.queued[0][OVH_SLOT];
        end
        n.dg_run    = 1'b0;
        n.dg_banks  = '0;
        n.force_gnd = 1'b0;
      end else begin
        n.dg_cnt = st.dg_cnt - DG_ONE;
      end
    end
    if (trig) begin
      n.dg_run   = 1'b1;
      n.dg_cnt   = DG_LOAD;
      n.dg_banks = n.dg_banks | trig_banks;
    end
    // reset sequence
    enter_hold = !st.pin_s2 || (st.rst == RS_ARM && bus.sclk_rise);
    case (st.rst)
      RS_IDLE: begin
        n.rst_cnt = '0;
      end
      RS_ARM: begin
        n.rst_cnt = '0;
      end
      RS_HOLD: begin
        if (st.pin_s2 && bus.sclk_rise) begin
          n.rst       = RS_CLOCKED;
          n.rst_cnt   = 7'h01;
          n.queued    = {(NUM_BANKS*SLOTS){DEFAULT_CODE}};
          n.alarm_cfg = ALARM_CFG_AFTER;
        end
      end
      RS_CLOCKED: begin
        if (bus.sclk_rise) begin
          if (st.rst_cnt == RST_CLK_EDGES - 7'h01) begin
            n.rst      = RS_IDLE;
            n.dg_run   = 1'b1;
            n.dg_cnt   = DG_LOAD;
            n.dg_banks = '1;
          end else begin
            n.rst_cnt = st.rst_cnt + 7'h01;
          end
        end
      end
      default: begin
        n.rst = RS_HOLD;
      end
    endcase
    if (enter_hold) begin
      n.rst       = RS_HOLD;
      n.rst_cnt   = '0;
      n.ctrl      = {(NUM_BANKS*NUM_CTRL){CTRL_RST}};
      n.mode      = '0;
      n.corr_en   = 1'b0;
      n.gain      = GAIN_RST;
      n.offset    = OFFSET_RST;
      n.alarm_cfg = ALARM_CFG_RST;
      n.upd_banks = '0;
      n.upd_cnt   = '0;
      n.dg_run    = 1'b0;
      n.dg_banks  = '0;
      n.force_gnd = 1'b1;
    end
    n.busy = (n.rst != RS_IDLE) || (n.upd_banks != '0);
    for (int b = 0; b < NUM_BANKS; b++) begin
      n.pin_act[b] = !n.force_gnd && n.ctrl[b][CTRL_PIN][PIN_EN_BIT];
      n.pmu_act[b] = !n.force_gnd && n.ctrl[b][CTRL_PMU][PMU_EN_BIT];
    end
    n.sys_pmu = !n.force_gnd && n.ctrl[0][CTRL_PMU][SYS_PMU_BIT];
  end

  // read data for the serial front end
  always_comb begin
    rd_ch       = bus.hdr[HDR_CH1] && !bus.hdr[HDR_CH0];
    rd_addr     = bus.hdr[ADDR_W-1:0];
    rd_ci       = ctrl_idx(rd_addr);
    bus.rd_data = '0;
    if (rd_addr <= DAC_ADDR_LAST) begin
      bus.rd_data = st.queued[rd_ch][rd_addr[3:0]];
    end else if (rd_addr == ADDR_LVL_CTRL) begin
      bus.rd_data[MODE_BIT]    = st.mode[rd_ch];
      bus.rd_data[CORR_EN_BIT] = !rd_ch && st.corr_en;
    end else if (rd_addr == ADDR_GAIN && !rd_ch) begin
      bus.rd_data = st.gain;
    end else if (rd_addr == ADDR_OFFSET && !rd_ch) begin
      bus.rd_data = st.offset;
    end else if (rd_addr == ADDR_ALARM_CFG && !rd_ch) begin
      bus.rd_data = st.alarm_cfg;
    end else if (rd_addr == ADDR_ALARM) begin
      bus.rd_data[STAT_BUSY_BIT] = st.busy;
      bus.rd_data[STAT_DG_BIT]   = st.dg_run;
      bus.rd_data[STAT_GND_BIT]  = st.force_gnd;
    end else if (rd_ci != NO_CTRL && (!rd_ch || rd_addr != ADDR_VHH)) begin
      bus.rd_data = st.ctrl[rd_ch][rd_ci];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      st <= '0;
    end else begin
      st <= n;
    end
  end

  assign o_busy_n_out         = 1'b0;
  assign o_busy_n_oe          = st.busy;
  assign o_level_code         = st.level;
  assign o_levels_grounded    = st.force_gnd;
  assign o_test_pins_grounded = st.force_gnd;
  assign o_pin_elec_active    = st.pin_act;
  assign o_pmu_active         = st.pmu_act;
  assign o_sys_pmu_closed     = st.sys_pmu;
  assign o_alarm_cfg          = st.alarm_cfg;
  assign o_deglitch_active    = st.dg_run;

  // checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  hard_hold_a: assert property (!st.pin_s2 |=> st.rst == RS_HOLD && st.busy)
    else $error("reset pin low did not hold reset");
  soft_arm_a: assert property (wr && chs[0] && addr == ADDR_SPI_CTRL && wdata[SOFT_RST_BIT] |=> st.rst == RS_ARM)
    else $error("soft reset write not armed");
  reset_state_a: assert property (st.rst == RS_HOLD |-> st.force_gnd && st.pin_act == '0 && st.pmu_act == '0 && !st.sys_pmu)
    else $error("static reset outputs wrong");
  hold_stay_a: assert property (st.rst == RS_HOLD && !bus.sclk_rise |=> st.rst == RS_HOLD)
    else $error("static reset left without sclk edge");
  clocked_busy_a: assert property (st.rst == RS_CLOCKED |-> st.busy && st.rst_cnt < RST_CLK_EDGES)
    else $error("busy dropped during clocked reset");
  alarm_load_a: assert property (st.rst == RS_CLOCKED |-> st.alarm_cfg == ALARM_CFG_AFTER)
    else $error("alarm configuration not loaded");
  reset_end_a: assert property (st.rst == RS_CLOCKED ##1 st.rst == RS_IDLE |-> !st.busy && st.dg_run && st.dg_cnt == DG_LOAD)
    else $error("reset end did not start deglitch");
  update_trig_a: assert property ($fell(st.upd_banks != '0) && st.rst == RS_IDLE |-> st.dg_run && st.dg_cnt == DG_LOAD)
    else $error("update did not trigger deglitch");
  level_hold_a: assert property (st.dg_run && st.dg_cnt > DG_ONE |=> $stable(st.level))
    else $error("levels moved before deglitch expiry");
  pin_override_a: assert property ((st.pin_act & ~{st.ctrl[1][CTRL_PIN][PIN_EN_BIT], st.ctrl[0][CTRL_PIN][PIN_EN_BIT]}) == '0)
    else $error("pin electronics active while disabled");

  soft_reset_c: cover property (st.rst == RS_ARM ##[1:40] st.rst == RS_HOLD);
  reset_done_c: cover property (st.rst == RS_CLOCKED ##1 st.rst == RS_IDLE);
  dual_trig_c: cover property (trig && trig_banks == 2'h3);
  expiry_c: cover property ($fell(st.dg_run) && !st.force_gnd);
endmodule : ldur_level_ctrl
`default_nettype wire

// ===== design/ldur_pkg.sv
`default_nettype none
package ldur_pkg;
  // serial word layout
  localparam int DATA_W     = 16;
  localparam int ADDR_W     = 5;
  localparam int FRAME_BITS = 24;
  localparam int HDR_BITS   = 8;
  localparam int CNT_W      = 5;
  localparam int RW_POS     = 23;
  localparam int CH1_POS    = 22;
  localparam int CH0_POS    = 21;
  localparam int ADDR_MSB   = 20;
  localparam int ADDR_LSB   = 16;
  localparam int HDR_CH1    = 6;
  localparam int HDR_CH0    = 5;
  // banks and converter slots
  localparam int NUM_BANKS  = 2;
  localparam int SLOTS      = 16;
  localparam int NUM_CTRL   = 5;
  // register addresses
  localparam logic [ADDR_W-1:0] DAC_ADDR_LAST  = 5'h0F;
  localparam logic [ADDR_W-1:0] ADDR_OVH       = 5'h0C;
  localparam logic [ADDR_W-1:0] ADDR_LVL_CTRL  = 5'h11;
  localparam logic [ADDR_W-1:0] ADDR_SPI_CTRL  = 5'h12;
  localparam logic [ADDR_W-1:0] ADDR_GAIN      = 5'h14;
  localparam logic [ADDR_W-1:0] ADDR_OFFSET    = 5'h15;
  localparam logic [ADDR_W-1:0] ADDR_VHH       = 5'h18;
  localparam logic [ADDR_W-1:0] ADDR_PIN       = 5'h19;
  localparam logic [ADDR_W-1:0] ADDR_PMU       = 5'h1A;
  localparam logic [ADDR_W-1:0] ADDR_CMP       = 5'h1C;
  localparam logic [ADDR_W-1:0] ADDR_ALARM_CFG = 5'h1D;
  localparam logic [ADDR_W-1:0] ADDR_ALARM     = 5'h1E;
  localparam logic [ADDR_W-1:0] ADDR_EDGE      = 5'h1F;
  // field positions
  localparam int CORR_EN_BIT   = 0;
  localparam int MODE_BIT      = 1;
  localparam int APPLY_BIT     = 2;
  localparam int SOFT_RST_BIT  = 0;
  localparam int PIN_EN_BIT    = 0;
  localparam int PMU_EN_BIT    = 0;
  localparam int SYS_PMU_BIT   = 1;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DG_BIT   = 1;
  localparam int STAT_GND_BIT  = 2;
  // reset values
  localparam logic [DATA_W-1:0] CTRL_RST      = 16'h0000;
  localparam logic [DATA_W-1:0] GAIN_RST      = 16'hFFFF;
  localparam logic [DATA_W-1:0] OFFSET_RST    = 16'h8000;
  localparam logic [DATA_W-1:0] CODE_MID      = 16'h8000;
  localparam logic [DATA_W-1:0] DEFAULT_CODE  = 16'h4000;
  localparam logic [DATA_W-1:0] ALARM_CFG_RST = 16'h0000;
  localparam logic [7:0]        THERM_THRESH_C = 8'h64;
  // thermal enabled at bit 0, measure-unit and overvolt alarms off at bits 1 and 2
  localparam logic [DATA_W-1:0] ALARM_CFG_AFTER = {THERM_THRESH_C, 8'h01};
  // timing
  localparam logic [6:0] RST_CLK_EDGES      = 7'h40;
  localparam logic [2:0] UPDATE_DELAY_EDGES = 3'h4;
  localparam int CLK_PERIOD_NS = 10;
  localparam int DEGLITCH_NS   = 3000;
  localparam int DEGLITCH_CYC  = DEGLITCH_NS / CLK_PERIOD_NS;
endpackage : ldur_pkg
`default_nettype wire

// ===== design/ldur_spi_front.sv
`timescale 1ns/100ps
`default_nettype none
module ldur_spi_front
  import ldur_pkg::*;
(
  input  wire logic      i_clk,
  input  wire logic      i_sys_rst,
  input  wire logic      i_sclk,
  input  wire logic      i_cs_n,
  input  wire logic      i_mosi,
  output var  logic      o_miso,
  ldur_spi_if.front      bus
);
  localparam logic [CNT_W-1:0] CNT_MAX   = 5'h1F;
  localparam logic [CNT_W-1:0] CNT_HDR   = CNT_W'(HDR_BITS - 1);
  localparam logic [CNT_W-1:0] CNT_FRAME = CNT_W'(FRAME_BITS);

  typedef struct packed {
    logic                  sclk_s1;
    logic                  sclk_s2;
    logic                  sclk_d;
    logic                  cs_s1;
    logic                  cs_s2;
    logic                  cs_d;
    logic                  mosi_s1;
    logic                  mosi_s2;
    logic [FRAME_BITS-1:0] sh;
    logic [CNT_W-1:0]      cnt;
    logic [DATA_W-1:0]     out_sh;
    logic                  miso;
    logic                  rise;
    logic                  done;
    logic                  hdr_done;
    logic                  load;
  } ldur_front_s;

  ldur_front_s st;
  ldur_front_s n;

  always_comb begin
    n          = st;
    n.rise     = 1'b0;
    n.done     = 1'b0;
    n.hdr_done = 1'b0;
    n.load     = st.hdr_done;
    n.sclk_s1  = i_sclk;
    n.sclk_s2  = st.sclk_s1;
    n.sclk_d   = st.sclk_s2;
    n.cs_s1    = i_cs_n;
    n.cs_s2    = st.cs_s1;
    n.cs_d     = st.cs_s2;
    n.mosi_s1  = i_mosi;
    n.mosi_s2  = st.mosi_s1;
    // frame start
    if (st.cs_d && !st.cs_s2) begin
      n.cnt = '0;
    end
    // rising sclk: sample data, msb first
    if (st.sclk_s2 && !st.sclk_d) begin
      n.rise = 1'b1;
      if (!st.cs_s2) begin
        n.sh = {st.sh[FRAME_BITS-2:0], st.mosi_s2};
        if (st.cnt != CNT_MAX) begin
          n.cnt = st.cnt + 5'h01;
        end
        if (st.cnt == CNT_HDR) begin
          n.hdr_done = 1'b1;
        end
      end
    end
    // falling sclk: shift read data out
    if (!st.sclk_s2 && st.sclk_d && !st.cs_s2) begin
      n.miso   = st.out_sh[DATA_W-1];
      n.out_sh = {st.out_sh[DATA_W-2:0], 1'b0};
    end
    if (st.load) begin
      n.out_sh = bus.rd_data;
    end
    // frame end on chip-select release, full words only
    if (!st.cs_d && st.cs_s2 && st.cnt == CNT_FRAME) begin
      n.done = 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      st <= '0;
    end else begin
      st <= n;
    end
  end

  assign o_miso         = st.miso;
  assign bus.sclk_rise  = st.rise;
  assign bus.frame_done = st.done;
  assign bus.frame      = st.sh;
  assign bus.hdr        = st.sh[HDR_BITS-1:0];
endmodule : ldur_spi_front
`default_nettype wire

// ===== design/ldur_spi_if.sv
`timescale 1ns/100ps
`default_nettype none
interface ldur_spi_if;
  import ldur_pkg::*;
  logic                  sclk_rise;
  logic                  frame_done;
  logic [FRAME_BITS-1:0] frame;
  logic [HDR_BITS-1:0]   hdr;
  logic [DATA_W-1:0]     rd_data;
  modport front (output sclk_rise, output frame_done, output frame, output hdr, input rd_data);
  modport core  (input sclk_rise, input frame_done, input frame, input hdr, output rd_data);
endinterface : ldur_spi_if
`default_nettype wire

// ===== verif/ldur_spi_host.sv
`timescale 1ns/100ps
`default_nettype none
module ldur_spi_host (
  input  wire logic i_clk,
  output var  logic o_sclk,
  output var  logic o_cs_n,
  output var  logic o_mosi,
  input  wire logic i_miso,
  output var  logic [15:0] o_rd
);
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_mosi = 1'b0;
    o_rd   = 16'h0000;
  end
  task automatic half_per;
    repeat (8) @(posedge i_clk);
    #1;
  endtask : half_per
  // one word msb first, sclk idle low between frames
  task automatic send(input logic [23:0] w);
    o_cs_n = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      o_mosi = w[i];
      half_per();
      // read data settles mid low phase, take it just before the rise
      o_rd   = {o_rd[14:0], i_miso};
      o_sclk = 1'b1;
      half_per();
      o_sclk = 1'b0;
    end
    half_per();
    o_cs_n = 1'b1;
    o_mosi = ~o_mosi;
    half_per();
  endtask : send
  // free clocks while busy is pending
  task automatic ticks(input int n);
    repeat (n) begin
      half_per();
      o_sclk = 1'b1;
      half_per();
      o_sclk = 1'b0;
    end
  endtask : ticks
endmodule : ldur_spi_host
`default_nettype wire

// ===== verif/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import ldur_pkg::*;
  typedef struct packed {
    logic [23:0] w;
    logic [4:0]  idx;
    logic [15:0] exp_v;
  } ldur_row_s;
  logic                              i_clk;
  logic                              i_sys_rst;
  logic                              i_chip_reset_n;
  logic                              sclk;
  logic                              cs_n;
  logic                              mosi;
  logic                              busy_oe;
  logic                              gnd;
  logic                              dg;
  logic [NUM_BANKS*SLOTS*DATA_W-1:0] lvl;
  logic [DATA_W-1:0]                 alarm;
  logic                              miso;
  logic                              busy_lvl;
  logic                              tgnd;
  logic                              sys_pmu;
  logic [1:0]                        pin_act;
  logic [1:0]                        pmu_act;
  logic [15:0]                       rd;
  int                                error_cnt = 0;
  int                                comparisons = 0;
  ldur_row_s                         rows [5] = '{
    '{24'h231234, 5'd3, 16'h1234},
    '{24'h455678, 5'd21, 16'h5678},
    '{24'h679ABC, 5'd7, 16'h9ABC},
    '{24'h000000, 5'd23, 16'h9ABC},
    '{24'h310002, 5'd3, 16'h1234}};
  ldur_spi_host host_u (.i_clk(i_clk), .o_sclk(sclk), .o_cs_n(cs_n), .o_mosi(mosi), .i_miso(miso), .o_rd(rd));
  ldur_level_ctrl dut_u (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_chip_reset_n(i_chip_reset_n),
    .i_sclk(sclk), .i_cs_n(cs_n), .i_mosi(mosi), .o_miso(miso),
    .o_busy_n_out(busy_lvl), .o_busy_n_oe(busy_oe), .o_level_code(lvl),
    .o_levels_grounded(gnd), .o_test_pins_grounded(tgnd), .o_pin_elec_active(pin_act),
    .o_pmu_active(pmu_act), .o_sys_pmu_closed(sys_pmu), .o_alarm_cfg(alarm),
    .o_deglitch_active(dg));
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic wrap_up;
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : wrap_up
  // outputs are read one step after the edge that launches them
  task automatic wait_clk(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask : wait_clk
  task automatic settle;
    host_u.ticks(6);
    wait_clk(320);
  endtask : settle
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  initial begin
    #500000;
    error_cnt++;
    wrap_up();
  end
  initial begin
    i_sys_rst = 1'b1;
    i_chip_reset_n = 1'b1;
    repeat (6) @(posedge i_clk);
    #1 i_sys_rst = 1'b0;
    host_u.ticks(62);
    wait_clk(5);
    chk("busy_mid", 16'h0001, {15'h0, busy_oe});
    host_u.ticks(3);
    wait_clk(5);
    chk("busy_end", 16'h0000, {15'h0, busy_oe});
    chk("dg_run", 16'h0001, {15'h0, dg});
    chk("alarm", 16'h6401, alarm);
    chk("lvl_hold", 16'h0000, lvl[15:0]);
    chk("busy_pin", 16'h0000, {15'h0, busy_lvl});
    wait_clk(320);
    chk("lvl_rst", 16'h4000, lvl[15:0]);
    chk("gnd_off", 16'h0000, {15'h0, gnd});
    chk("tpin_off", 16'h0000, {15'h0, tgnd});
    foreach (rows[k]) begin
      if (rows[k].w != 24'h0)
        host_u.send(rows[k].w);
      settle();
      chk("level", rows[k].exp_v, lvl[{rows[k].idx, 4'h0} +: 16]);
    end
    host_u.send(24'h23FFFF);
    settle();
    chk("queued", 16'h1234, lvl[63:48]);
    host_u.send(24'h310006);
    settle();
    chk("applied", 16'hFFFF, lvl[63:48]);
    host_u.send(24'h23AAAA);
    host_u.send(24'h310000);
    host_u.send(24'h240001);
    settle();
    chk("flush", 16'hAAAA, lvl[63:48]);
    // overvolt-high on channel 0 is released by the bank 1 update that its own write requests
    host_u.send(24'h2C1111);
    host_u.send(24'h452222);
    settle();
    chk("ovh", 16'h1111, lvl[207:192]);
    chk("ch1_lvl", 16'h2222, lvl[351:336]);
    host_u.send(24'h790001);
    host_u.send(24'h7A0003);
    chk("pin_on", 16'h0003, {14'h0, pin_act});
    chk("pmu_on", 16'h0003, {14'h0, pmu_act});
    chk("sys_pmu", 16'h0001, {15'h0, sys_pmu});
    host_u.send(24'h590000);
    chk("pin_one", 16'h0001, {14'h0, pin_act});
    host_u.send(24'h347FFF);
    host_u.send(24'h540005);
    host_u.send(24'hB40000);
    chk("gain", 16'h7FFF, rd);
    host_u.send(24'h310001);
    host_u.send(24'h241000);
    settle();
    chk("corr", 16'h0800, lvl[79:64]);
    host_u.send(24'hA40000);
    chk("rd_code", 16'h0800, rd);
    host_u.send(24'hB20000);
    chk("rd_rsvd", 16'h0000, rd);
    i_chip_reset_n = 1'b0;
    wait_clk(6);
    chk("pin_busy", 16'h0001, {15'h0, busy_oe});
    chk("pin_gnd", 16'h0001, {15'h0, gnd});
    chk("pin_tpin", 16'h0001, {15'h0, tgnd});
    chk("pin_alarm", 16'h0000, alarm);
    chk("pin_off", 16'h0000, {14'h0, pin_act});
    chk("pmu_off", 16'h0000, {14'h0, pmu_act});
    chk("sys_off", 16'h0000, {15'h0, sys_pmu});
    i_chip_reset_n = 1'b1;
    wait_clk(20);
    chk("hold_busy", 16'h0001, {15'h0, busy_oe});
    host_u.ticks(63);
    wait_clk(5);
    chk("hw_busy63", 16'h0001, {15'h0, busy_oe});
    host_u.ticks(1);
    wait_clk(5);
    chk("hw_busy64", 16'h0000, {15'h0, busy_oe});
    wait_clk(320);
    chk("hw_lvl", 16'h4000, lvl[63:48]);
    host_u.send(24'h320001);
    chk("soft_arm", 16'h0001, {15'h0, busy_oe});
    chk("soft_wait", 16'h0000, {15'h0, gnd});
    host_u.ticks(1);
    wait_clk(5);
    chk("soft_gnd", 16'h0001, {15'h0, gnd});
    host_u.ticks(63);
    wait_clk(5);
    chk("soft_busy", 16'h0001, {15'h0, busy_oe});
    host_u.ticks(1);
    wait_clk(5);
    chk("soft_end", 16'h0000, {15'h0, busy_oe});
    wait_clk(320);
    chk("soft_lvl", 16'h4000, lvl[79:64]);
    wrap_up();
  end
endmodule : testbench
`default_nettype wire
